// *** design/pmvc_top.sv ***
// vector current control datapath with carrier pwm
`timescale 1ns/100ps
// Notes on behaviour
// - three phase currents to alpha beta
// - rotate by angle into d q
// - deviation is command minus measured
// - incremental pi per axis
// - inverse rotation back to alpha beta
// - alpha beta to three phase voltages
// - high while voltage above carrier
// - one pwm cycle per carrier period
// - complementary pair with dead time
// - dead time is 2.5 us
// - compares and period load at trough
// - sampling request at carrier trough
module pmvc_top
  import pmvc_pkg::*;
#(
  parameter int HALF = pmvc_pkg::CARRIER_HALF_CYCLES,
  parameter int DEAD = pmvc_pkg::DEAD_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // sample in
  input wire logic sample_valid_i,
  input wire logic signed [17:0] phase_u_current_i,
  input wire logic signed [17:0] phase_v_current_i,
  input wire logic signed [17:0] phase_w_current_i,
  input wire logic signed [17:0] cos_theta_i,
  input wire logic signed [17:0] sin_theta_i,
  // commands, gains, sample interval and carrier half period
  input wire logic signed [17:0] d_current_command_i,
  input wire logic signed [17:0] q_current_command_i,
  input wire logic signed [17:0] proportional_gain_i,
  input wire logic signed [17:0] integral_gain_i,
  input wire logic signed [17:0] sample_interval_i,
  input wire logic [15:0] carrier_half_i,
  // gate drives, sampling request, phase voltages and result valid
  output logic sample_request_o,
  output logic [2:0] upper_o,
  output logic [2:0] lower_o,
  output logic signed [17:0] phase_u_voltage_o,
  output logic signed [17:0] phase_v_voltage_o,
  output logic signed [17:0] phase_w_voltage_o,
  output logic result_valid_o
);
  import pmvc_pkg::*;

  typedef enum logic [2:0] {
    PMVC_IDLE = 3'b000,
    PMVC_ABC = 3'b001,
    PMVC_DQ = 3'b011,
    PMVC_PI = 3'b010,
    PMVC_INV = 3'b110,
    PMVC_UVW = 3'b111
  } pmvc_state_e;

  pmvc_state_e st_q;
  logic signed [17:0] ia_q, ib_q, id_q, iq_q;
  logic signed [17:0] ed_q, eq_q, vd_q, vq_q, va_q, vb_q;
  logic signed [17:0] cmpu_q, cmpv_q, cmpw_q;
  logic [15:0] half_q, cnt_q, limit_q;
  logic up_q, trough_q;
  logic [2:0] raw_q;
  logic signed [17:0] ed_d, eq_d, lim;
  logic [15:0] next_half;

  // ---------------------------------------------------------------
  // carrier
  // ---------------------------------------------------------------
  assign lim = 18'($signed({2'b00, half_q}));
  assign next_half = (carrier_half_i == 16'h0000) ? 16'(HALF) : carrier_half_i;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_q <= 16'h0000;
      up_q <= 1'b1;
      half_q <= 16'(HALF);
      limit_q <= 16'(HALF);
      trough_q <= 1'b0;
    end else begin
      trough_q <= 1'b0;
      if (up_q) begin
        if (cnt_q >= limit_q - 16'h0001) begin
          up_q <= 1'b0;
        end
        cnt_q <= cnt_q + 16'h0001;
      end else if (cnt_q == 16'h0001) begin
        cnt_q <= 16'h0000;
        up_q <= 1'b1;
        trough_q <= 1'b1;
        limit_q <= next_half;
        half_q <= next_half;
      end else begin
        cnt_q <= cnt_q - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sample_request_o <= 1'b0;
    end else begin
      sample_request_o <= trough_q;
    end
  end

  // ---------------------------------------------------------------
  // control sequence
  // ---------------------------------------------------------------
  // deviation per axis
  assign ed_d = pmvc_sat(20'(d_current_command_i) - 20'(id_q), lim);
  assign eq_d = pmvc_sat(20'(q_current_command_i) - 20'(iq_q), lim);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= PMVC_IDLE;
      ia_q <= 18'sh0_0000;
      ib_q <= 18'sh0_0000;
      id_q <= 18'sh0_0000;
      iq_q <= 18'sh0_0000;
      ed_q <= 18'sh0_0000;
      eq_q <= 18'sh0_0000;
      vd_q <= 18'sh0_0000;
      vq_q <= 18'sh0_0000;
      va_q <= 18'sh0_0000;
      vb_q <= 18'sh0_0000;
      phase_u_voltage_o <= 18'sh0_0000;
      phase_v_voltage_o <= 18'sh0_0000;
      phase_w_voltage_o <= 18'sh0_0000;
      result_valid_o <= 1'b0;
    end else begin
      result_valid_o <= 1'b0;
      unique case (st_q)
        PMVC_IDLE: begin
          if (sample_valid_i) begin
            st_q <= PMVC_ABC;
          end
        end
        PMVC_ABC: begin
          ia_q <= pmvc_sat(20'(pmvc_mul(K_S23, phase_u_current_i))
                  - 20'(pmvc_mul(K_S23_HALF, phase_v_current_i))
                  - 20'(pmvc_mul(K_S23_HALF, phase_w_current_i)),
                  18'sh1_ffff);
          ib_q <= pmvc_sat(20'(pmvc_mul(K_S23_SIN, phase_v_current_i))
                  - 20'(pmvc_mul(K_S23_SIN, phase_w_current_i)),
                  18'sh1_ffff);
          st_q <= PMVC_DQ;
        end
        PMVC_DQ: begin
          id_q <= pmvc_sat(20'(pmvc_mul(ia_q, cos_theta_i))
                  + 20'(pmvc_mul(ib_q, sin_theta_i)), 18'sh1_ffff);
          iq_q <= pmvc_sat(20'(pmvc_mul(ib_q, cos_theta_i))
                  - 20'(pmvc_mul(ia_q, sin_theta_i)), 18'sh1_ffff);
          st_q <= PMVC_PI;
        end
        PMVC_PI: begin
          vd_q <= pmvc_sat(20'(vd_q)
                  + 20'(pmvc_mul(proportional_gain_i, 18'(ed_d - ed_q)))
                  + 20'(pmvc_mul(pmvc_mul(integral_gain_i, ed_d),
                                 sample_interval_i)), lim);
          vq_q <= pmvc_sat(20'(vq_q)
                  + 20'(pmvc_mul(proportional_gain_i, 18'(eq_d - eq_q)))
                  + 20'(pmvc_mul(pmvc_mul(integral_gain_i, eq_d),
                                 sample_interval_i)), lim);
          ed_q <= ed_d;
          eq_q <= eq_d;
          st_q <= PMVC_INV;
        end
        PMVC_INV: begin
          va_q <= pmvc_sat(20'(pmvc_mul(vd_q, cos_theta_i))
                  - 20'(pmvc_mul(vq_q, sin_theta_i)), 18'sh1_ffff);
          vb_q <= pmvc_sat(20'(pmvc_mul(vd_q, sin_theta_i))
                  + 20'(pmvc_mul(vq_q, cos_theta_i)), 18'sh1_ffff);
          st_q <= PMVC_UVW;
        end
        PMVC_UVW: begin
          phase_u_voltage_o <= pmvc_sat(20'(pmvc_mul(K_S23, va_q)), lim);
          phase_v_voltage_o <= pmvc_sat(20'(pmvc_mul(K_S23_SIN, vb_q))
                               - 20'(pmvc_mul(K_S23_HALF, va_q)), lim);
          phase_w_voltage_o <= pmvc_sat(-20'(pmvc_mul(K_S23_SIN, vb_q))
                               - 20'(pmvc_mul(K_S23_HALF, va_q)), lim);
          result_valid_o <= 1'b1;
          st_q <= PMVC_IDLE;
        end
        default: begin
          st_q <= PMVC_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // compare and modulate
  // ---------------------------------------------------------------
  // compare load at trough
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cmpu_q <= 18'sh0_0000;
      cmpv_q <= 18'sh0_0000;
      cmpw_q <= 18'sh0_0000;
    end else if (trough_q) begin
      cmpu_q <= phase_u_voltage_o;
      cmpv_q <= phase_v_voltage_o;
      cmpw_q <= phase_w_voltage_o;
    end
  end

  // carrier mapped to signed -half..+half
  logic signed [17:0] carrier;
  assign carrier = 18'($signed({2'b00, cnt_q, 1'b0})) - lim;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      raw_q <= {3{PWM_RST}};
    end else begin
      raw_q <= {cmpw_q > carrier, cmpv_q > carrier, cmpu_q > carrier};
    end
  end

  for (genvar g = 0; g < 3; g++) begin : g_dead
    pmvc_dead #(.DEAD(DEAD)) u_dead (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .pwm_i(raw_q[g]),
      .hi_o(upper_o[g]),
      .lo_o(lower_o[g])
    );
  end
endmodule : pmvc_top

// *** design/pmvc_pkg.sv ***
// constants and shared math for the vector current pwm block
package pmvc_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam real DEAD_TIME_US = 2.5;
  localparam int DEAD_CYCLES = int'($ceil(DEAD_TIME_US * CLK_HZ / 1.0e6));
  localparam real CARRIER_PERIOD_US = 125.0;
  localparam int CARRIER_HALF_CYCLES =
    int'($floor(CARRIER_PERIOD_US * CLK_HZ / 2.0e6));
  // ---------------------------------------------------------------
  // fixed point: 18-bit q3.14 style with sign, value 1.0 = 2**FRAC
  // ---------------------------------------------------------------
  localparam int FRAC = 14;
  // sqrt(2/3), sqrt(2/3)/2, sqrt(2/3)*sin(2pi/3) in q.14
  localparam logic signed [17:0] K_S23 = 18'sd13377;
  localparam logic signed [17:0] K_S23_HALF = 18'sd6689;
  localparam logic signed [17:0] K_S23_SIN = 18'sd11585;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic PWM_RST = 1'b0;

  // scaled product, result truncated to 18 bits
  function automatic logic signed [17:0] pmvc_mul(
    input logic signed [17:0] a,
    input logic signed [17:0] b
  );
    logic signed [35:0] p;
    p = a * b;
    return 18'(p >>> FRAC);
  endfunction : pmvc_mul

  // saturate a wide value to +-lim
  function automatic logic signed [17:0] pmvc_sat(
    input logic signed [19:0] v,
    input logic signed [17:0] lim
  );
    logic signed [19:0] l;
    l = 20'(lim);
    if (v > l) begin
      return lim;
    end else if (v < -l) begin
      return -lim;
    end
    return 18'(v);
  endfunction : pmvc_sat
endpackage : pmvc_pkg

// *** design/pmvc_dead.sv ***
// complementary output pair with dead time for one phase
`timescale 1ns/100ps
module pmvc_dead #(
  parameter int DEAD = 100
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // raw pwm
  input wire logic pwm_i,
  // gate drives
  output logic hi_o,
  output logic lo_o
);
  logic [15:0] cnt_q;
  logic lvl_q;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lvl_q <= 1'b0;
      cnt_q <= 16'h0000;
      hi_o <= 1'b0;
      lo_o <= 1'b0;
    end else if (pwm_i != lvl_q) begin
      lvl_q <= pwm_i;
      cnt_q <= 16'h0000;
      hi_o <= 1'b0;
      lo_o <= 1'b0;
    end else if (cnt_q < 16'(DEAD)) begin
      cnt_q <= cnt_q + 16'h0001;
    end else begin
      hi_o <= lvl_q;
      lo_o <= ~lvl_q;
    end
  end
endmodule : pmvc_dead

// *** tb/pmvc_props.sv ***
// assertions for the vector current pwm block
`timescale 1ns/100ps
module pmvc_props #(
  parameter int HALF = 20,
  parameter int DEAD = 3
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic sample_valid_i,
  input wire logic sample_request_o,
  input wire logic result_valid_o,
  input wire logic [2:0] upper_o,
  input wire logic [2:0] lower_o,
  input wire logic signed [17:0] phase_u_voltage_o
);
  localparam int PER = 2 * HALF;
  logic [15:0] gap_q;
  logic seen_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gap_q <= '0;
      seen_q <= 1'b0;
    end else begin
      gap_q <= (upper_o[0] | lower_o[0]) ? '0 : gap_q + 16'h0001;
      seen_q <= seen_q | upper_o[0] | lower_o[0];
    end
  end
  a_no_shoot: assert property ((upper_o & lower_o) == 3'h0)
    else $error("upper and lower active together");
  a_dead_exact: assert property (seen_q && ($rose(upper_o[0]) ||
    $rose(lower_o[0])) |-> gap_q == DEAD + 1)
    else $error("dead gap length wrong");
  a_gap_bound: assert property (seen_q |-> gap_q <= DEAD + 1)
    else $error("both gates low too long");
  a_req_period: assert property (sample_request_o |-> ##PER
    sample_request_o)
    else $error("request spacing wrong");
  a_req_pulse: assert property (sample_request_o |=>
    !sample_request_o)
    else $error("request longer than one cycle");
  a_result_lat: assert property (result_valid_o |->
    $past(sample_valid_i, 6))
    else $error("result without sample six cycles back");
  a_volt_hold: assert property (!result_valid_o |->
    $stable(phase_u_voltage_o))
    else $error("voltage moved without result");
  a_volt_sat: assert property (phase_u_voltage_o <= HALF &&
    phase_u_voltage_o >= -HALF)
    else $error("voltage outside carrier range");
  c_result: cover property (result_valid_o);
  c_dead: cover property (seen_q && $rose(upper_o[0]));
  c_req: cover property (sample_request_o);
endmodule : pmvc_props
bind pmvc_top pmvc_props #(.HALF(HALF), .DEAD(DEAD)) i_pmvc_props (
  .clk_i, .sys_rst_i, .sample_valid_i, .sample_request_o,
  .result_valid_o, .upper_o, .lower_o, .phase_u_voltage_o);

// *** tb/pmvc_plant.sv ***
// sensor and gate model for the vector current pwm block
`timescale 1ns/100ps
module pmvc_plant #(
  parameter int PER = 40
) (
  input wire logic clk_i,
  input wire logic arm_i,
  input wire logic req_i,
  input wire logic up_i,
  input wire logic lo_i,
  output logic valid_o,
  output logic [7:0] up_n_o,
  output logic [7:0] lo_n_o
);
  logic [PER-1:0] up_h = '0;
  logic [PER-1:0] lo_h = '0;
  initial valid_o = 1'b0;
  always @(negedge clk_i) valid_o <= arm_i && req_i;
  always @(posedge clk_i) begin
    up_h <= {up_h[PER-2:0], up_i};
    lo_h <= {lo_h[PER-2:0], lo_i};
  end
  assign up_n_o = 8'($countones(up_h));
  assign lo_n_o = 8'($countones(lo_h));
endmodule : pmvc_plant

// *** tb/pmvc_top_tb_top.sv ***
// testbench for the vector current pwm block
`timescale 1ns/100ps
module pmvc_top_tb_top;
  import pmvc_pkg::*;
  localparam logic signed [17:0] ONE = 18'sh0_4000;
  logic clk_i = 0, sys_rst_i = 1, arm = 0;
  logic sample_valid_i, sample_request_o, result_valid_o;
  logic signed [17:0] iu = 0, iv = 0, idc = 0;
  logic signed [17:0] cs = ONE, sn = 0, iq = 0, kp = 0;
  logic signed [17:0] vu, vv, vw;
  logic [15:0] hf = 16'h0014;
  logic [2:0] up, lo;
  logic [7:0] up_n, lo_n;
  int fails = 0, comparisons = 0, cyc = 0;
  always #12.5 clk_i = ~clk_i;
  pmvc_top #(.HALF(20), .DEAD(3)) i_pmvc_top (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .sample_valid_i(sample_valid_i),
    .phase_u_current_i(iu), .phase_v_current_i(iv),
    .phase_w_current_i(18'sh0_0000), .cos_theta_i(cs), .sin_theta_i(sn),
    .d_current_command_i(idc), .q_current_command_i(iq),
    .proportional_gain_i(kp), .integral_gain_i(ONE),
    .sample_interval_i(ONE), .carrier_half_i(hf),
    .sample_request_o(sample_request_o), .upper_o(up), .lower_o(lo),
    .phase_u_voltage_o(vu), .phase_v_voltage_o(vv),
    .phase_w_voltage_o(vw), .result_valid_o(result_valid_o));
  pmvc_plant #(.PER(40)) i_pmvc_plant (.clk_i(clk_i), .arm_i(arm),
    .req_i(sample_request_o), .up_i(up[0]), .lo_i(lo[0]),
    .valid_o(sample_valid_i), .up_n_o(up_n), .lo_n_o(lo_n));
  // ----
  // shared tasks
  // ----
  task automatic check(logic signed [17:0] s, logic signed [17:0] e,
    int t);
    int d;
    d = s - e;
    comparisons++;
    if ($isunknown(s) || d > t || -d > t) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check
  task automatic samp;
    int n;
    n = 0;
    @(negedge clk_i) arm <= 1'b1;
    while (result_valid_o !== 1'b1 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    arm <= 1'b0;
    check(18'(n < 200), 18'sh0_0001, 0);
  endtask : samp
  task automatic close_out;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  // ----
  // scenarios
  // ----
  task automatic t_first;
    iq = 18'sh0_0010;
    samp();
    check(vu, 18'sh0_0000, 0);
    check(vv, 18'sh0_000b, 1);
    check(vw, -18'sh0_000b, 1);
    repeat (120) @(negedge clk_i);
    check(18'(up_n), 18'sh0_000f, 0);
    check(18'(lo_n), 18'sh0_0011, 0);
    $display("t_first done");
  endtask : t_first
  task automatic t_sat;
    samp();
    check(vv, 18'sh0_000e, 1);
    check(vu, 18'sh0_0000, 0);
    $display("t_sat done");
  endtask : t_sat
  task automatic t_rot;
    @(negedge clk_i) sys_rst_i = 1;
    repeat (10) @(negedge clk_i);
    sys_rst_i = 0;
    check(vu, 18'sh0_0000, 0);
    iu = 18'sh0_0010;
    iv = 18'sh0_0010;
    kp = ONE;
    cs = 18'sh0_0000;
    sn = ONE;
    idc = 18'sh0_0000;
    iq = 18'sh0_0000;
    samp();
    check(vu, -18'sh0_000b, 2);
    check(vv, -18'sh0_0009, 2);
    check(vw, 18'sh0_0013, 2);
    $display("t_rot done");
  endtask : t_rot
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      close_out();
    end
  end
  initial begin
    repeat (10) @(negedge clk_i);
    sys_rst_i = 0;
    t_first();
    t_sat();
    t_rot();
    close_out();
  end
endmodule : pmvc_top_tb_top
